//--- cmpl_defs.svh
// cmpl_defs.svh: offsets, field positions, reset values and timing counts for the comparator control block
// assumes inclusion by bare name from the package and modules of this block
// Function
// RQ1: bit 6 of the control register switches the comparator off when 0 and on when 1.
// RQ2: clearing the enable bit forces the comparator output and its status bit low.
// RQ3: bit 5 passes the raw comparator result unchanged when 0 and inverts it when 1.
// RQ4: read-only bit 4 shows the polarity-adjusted comparison result and resets to 0.
// RQ5: bit 0 turns analog hysteresis off when 0 and on when 1, and resets to 1.
// RQ6: bit 7 and bits 3 to 1 always read zero and ignore writes.
// RQ7: each change of the output bit sets the interrupt flag, which with its enable raises a request.
// RQ8: in sleep or idle with the comparator enabled, an output change sets the flag and requests wake-up.
// RQ9: software sets the flag beforehand to block wake-up, so no wake-up is raised while it is set.
// RQ10: an enabled comparator keeps updating its output and flag during sleep or idle.
// RQ11: software should clear the enable bit when unused or before low-power modes.
// RQ12: with the comparator on shared pins, a port read gives 0 where port control is 1, else port data.
// RQ13: selecting a pin for a comparator input disconnects its pull-up.
// RQ14: the result can be driven onto a shared pin when the pin function selects it.
// RQ15: the analog result passes a synchroniser on the system clock before output bit and change detection.
`ifndef CMPL_DEFS_SVH
`define CMPL_DEFS_SVH

`define CMPL_ADDR_W 4
`define CMPL_OFS_CTRL 4'h0
`define CMPL_OFS_INT 4'h4
`define CMPL_OFS_PIN 4'h8
`define CMPL_OFS_PORT 4'hc

`define CMPL_BIT_EN 6
`define CMPL_BIT_POL 5
`define CMPL_BIT_OUT 4
`define CMPL_BIT_HYS 0
`define CMPL_CTRL_WMASK 8'h61

`define CMPL_BIT_FLAG 0
`define CMPL_BIT_IEN 1

`define CMPL_BIT_SEL_POS 0
`define CMPL_BIT_SEL_NEG 1
`define CMPL_BIT_SEL_OUT 2

`define CMPL_CTRL_RST 8'h01
`define CMPL_SYNC_STAGES 3

`endif

//--- cmpl_pkg.sv
// cmpl_pkg.sv: types shared by the comparator control block
// assumes cmpl_defs.svh is on the include path
`default_nettype none
`include "cmpl_defs.svh"
package cmpl_pkg;
   typedef enum logic [1:0] {
      CMPL_BUS_IDLE = 2'b00,
      CMPL_BUS_ACK = 2'b01,
      CMPL_BUS_REST = 2'b10
   } cmpl_bus_t;
endpackage
`default_nettype wire

//--- cmpl_sync_if.sv
// cmpl_sync_if.sv: carries the asynchronous comparator result and its synchronised form
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface cmpl_sync_if;
   logic raw;
   logic stable;
   logic changed;
   modport sync (input raw, output stable, output changed);
   modport user (output raw, input stable, input changed);
endinterface
`default_nettype wire

//--- cmpl_sync.sv
// cmpl_sync.sv: three-stage synchroniser with agreement check on the comparator result
// assumes CLK is the system clock and RST synchronous active high
`timescale 1ns/10ps
`default_nettype none
`include "cmpl_defs.svh"
module cmpl_sync (
   input wire logic clk,
   input wire logic rst,
   cmpl_sync_if.sync sif
);
   logic [`CMPL_SYNC_STAGES-1:0] stage_reg;
   logic stable_reg;

   // stage 0 only feeds stage 1; a change counts once stages 1 and 2 agree
   always_ff @(posedge clk) begin
      if (rst) begin
         stage_reg <= 3'h0;
      end else begin
         stage_reg <= {stage_reg[1:0], sif.raw}; // see RQ15
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stable_reg <= 1'b0;
      end else if (stage_reg[1] == stage_reg[2]) begin
         stable_reg <= stage_reg[2]; // see RQ15
      end
   end

   assign sif.stable = stable_reg;
   assign sif.changed = (stage_reg[1] == stage_reg[2]) && (stage_reg[2] != stable_reg);
endmodule // cmpl_sync
`default_nettype wire

//--- cmpl_ctrl.sv
// cmpl_ctrl.sv: comparator control register, output bit, change flag, wake-up and shared pin control
// assumes a classic wishbone master on CLK, an analog core outside, and one clock with synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "cmpl_defs.svh"
module cmpl_ctrl (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [`CMPL_ADDR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic WB_ACK_O,
   input wire logic COMP_RAW,
   output logic COMP_POWER_ON,
   output logic COMP_HYST_ON,
   input wire logic LOW_POWER_MODE,
   output logic COMP_IRQ,
   output logic COMP_WAKE,
   input wire logic [2:0] PORT_CTRL,
   input wire logic [2:0] PORT_DATA,
   output logic [2:0] PULLUP_CUT,
   output logic [2:0] PORT_READ,
   output logic COMP_PIN_OUT,
   output logic COMP_PIN_OE_N
);
   ////////////////////////////////////////////////////////////////////////////////
   // synchroniser
   // the raw result is asynchronous, so nothing downstream reads it directly
   cmpl_sync_if sif ();
   assign sif.raw = COMP_RAW;

   cmpl_sync u_sync (
      .clk(CLK),
      .rst(RST),
      .sif(sif)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave
   cmpl_pkg::cmpl_bus_t bus_reg;
   logic wr_hit;
   logic rd_hit;
   logic [31:0] rd_data;

   always_ff @(posedge CLK) begin
      if (RST) begin
         bus_reg <= cmpl_pkg::CMPL_BUS_IDLE;
      end else begin
         case (bus_reg)
            cmpl_pkg::CMPL_BUS_IDLE: begin
               if (WB_CYC_I && WB_STB_I) begin
                  bus_reg <= cmpl_pkg::CMPL_BUS_ACK;
               end
            end
            cmpl_pkg::CMPL_BUS_ACK: begin
               bus_reg <= cmpl_pkg::CMPL_BUS_REST;
            end
            cmpl_pkg::CMPL_BUS_REST: begin
               bus_reg <= cmpl_pkg::CMPL_BUS_IDLE;
            end
            default: begin
               bus_reg <= cmpl_pkg::CMPL_BUS_IDLE;
            end
         endcase
      end
   end

   // the write lands on the ack edge, where the master samples it
   assign wr_hit = (bus_reg == cmpl_pkg::CMPL_BUS_ACK) && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
   assign rd_hit = (bus_reg == cmpl_pkg::CMPL_BUS_IDLE) && WB_CYC_I && WB_STB_I;

   always_ff @(posedge CLK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= rd_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register
   localparam logic [7:0] ctrl_rst = `CMPL_CTRL_RST;
   logic ctrl_sel;
   logic int_sel;
   logic pin_sel;
   logic en_reg;
   logic pol_reg;
   logic hys_reg;
   logic out_reg;
   logic out_next;

   // one address decode per writable register, shared by the write side
   assign ctrl_sel = (WB_ADR_I == `CMPL_OFS_CTRL);
   assign int_sel = (WB_ADR_I == `CMPL_OFS_INT);
   assign pin_sel = (WB_ADR_I == `CMPL_OFS_PIN);

   always_ff @(posedge CLK) begin
      if (RST) begin
         en_reg <= ctrl_rst[`CMPL_BIT_EN];
         pol_reg <= ctrl_rst[`CMPL_BIT_POL];
         hys_reg <= ctrl_rst[`CMPL_BIT_HYS]; // see RQ5
      end else if (wr_hit && ctrl_sel) begin
         en_reg <= WB_DAT_I[`CMPL_BIT_EN]; // see RQ1
         pol_reg <= WB_DAT_I[`CMPL_BIT_POL]; // see RQ3
         hys_reg <= WB_DAT_I[`CMPL_BIT_HYS]; // see RQ5
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_POWER_ON <= 1'b0;
      end else begin
         COMP_POWER_ON <= en_reg; // see RQ1
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_HYST_ON <= 1'b1;
      end else begin
         COMP_HYST_ON <= hys_reg; // see RQ5
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output bit; keeps updating whatever the low-power state
   assign out_next = en_reg ? (sif.stable ^ pol_reg) : 1'b0; // see RQ2 see RQ3 see RQ4 see RQ10

   always_ff @(posedge CLK) begin
      if (RST) begin
         out_reg <= 1'b0; // see RQ4
      end else begin
         out_reg <= out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // change flag, interrupt and wake-up
   logic flag_reg;
   logic ien_reg;
   logic change;
   logic flag_wr;
   logic input_moved_reg;

   assign change = (out_next != out_reg);
   assign flag_wr = wr_hit && int_sel;

   // a change in the same cycle as a software clear wins
   always_ff @(posedge CLK) begin
      if (RST) begin
         flag_reg <= 1'b0;
      end else if (change) begin
         flag_reg <= 1'b1; // see RQ7
      end else if (flag_wr) begin
         flag_reg <= WB_DAT_I[`CMPL_BIT_FLAG];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ien_reg <= 1'b0;
      end else if (flag_wr) begin
         ien_reg <= WB_DAT_I[`CMPL_BIT_IEN];
      end
   end

   // high in the cycle where a pin-driven result move reaches the output bit
   always_ff @(posedge CLK) begin
      if (RST) begin
         input_moved_reg <= 1'b0;
      end else begin
         input_moved_reg <= sif.changed;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_IRQ <= 1'b0;
      end else begin
         COMP_IRQ <= flag_reg && ien_reg; // see RQ7
      end
   end

   // only pin-driven moves wake; a flag already set before sleep blocks wake-up
   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_WAKE <= 1'b0;
      end else begin
         COMP_WAKE <= LOW_POWER_MODE && en_reg && change && input_moved_reg && !flag_reg; // see RQ8 see RQ9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared pins
   logic [2:0] sel_reg;
   logic [2:0] port_ctrl_s0;
   logic [2:0] port_ctrl_s1;
   logic [2:0] port_ctrl_s2;
   logic [2:0] port_ctrl_ok;
   logic [2:0] port_data_s0;
   logic [2:0] port_data_s1;
   logic [2:0] port_data_s2;
   logic [2:0] port_data_ok;

   always_ff @(posedge CLK) begin
      if (RST) begin
         sel_reg <= 3'h0;
      end else if (wr_hit && pin_sel) begin
         sel_reg <= WB_DAT_I[2:0];
      end
   end

   // pin inputs are asynchronous; stage 0 only feeds stage 1
   always_ff @(posedge CLK) begin
      if (RST) begin
         port_ctrl_s0 <= 3'h0;
         port_ctrl_s1 <= 3'h0;
         port_ctrl_s2 <= 3'h0;
      end else begin
         port_ctrl_s0 <= PORT_CTRL;
         port_ctrl_s1 <= port_ctrl_s0;
         port_ctrl_s2 <= port_ctrl_s1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         port_data_s0 <= 3'h0;
         port_data_s1 <= 3'h0;
         port_data_s2 <= 3'h0;
      end else begin
         port_data_s0 <= PORT_DATA;
         port_data_s1 <= port_data_s0;
         port_data_s2 <= port_data_s1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
         always_ff @(posedge CLK) begin
            if (RST) begin
               port_ctrl_ok[gi] <= 1'b0;
               port_data_ok[gi] <= 1'b0;
            end else begin
               if (port_ctrl_s1[gi] == port_ctrl_s2[gi]) begin
                  port_ctrl_ok[gi] <= port_ctrl_s2[gi];
               end
               if (port_data_s1[gi] == port_data_s2[gi]) begin
                  port_data_ok[gi] <= port_data_s2[gi];
               end
            end
         end

         always_ff @(posedge CLK) begin
            if (RST) begin
               PULLUP_CUT[gi] <= 1'b0;
            end else begin
               PULLUP_CUT[gi] <= sel_reg[gi] && (gi != `CMPL_BIT_SEL_OUT); // see RQ13
            end
         end

         always_ff @(posedge CLK) begin
            if (RST) begin
               PORT_READ[gi] <= 1'b0;
            end else begin
               if (sel_reg[gi] && en_reg) begin
                  PORT_READ[gi] <= port_ctrl_ok[gi] ? 1'b0 : port_data_ok[gi]; // see RQ12
               end else begin
                  PORT_READ[gi] <= port_data_ok[gi];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_PIN_OUT <= 1'b0;
      end else begin
         COMP_PIN_OUT <= out_next; // see RQ14
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         COMP_PIN_OE_N <= 1'b1;
      end else begin
         COMP_PIN_OE_N <= !sel_reg[`CMPL_BIT_SEL_OUT]; // see RQ14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data; reserved bits read zero
   logic [7:0] ctrl_view;
   logic [7:0] int_view;

   // only the named positions are ever set, so reserved bits stay zero
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`CMPL_BIT_EN] = en_reg;
      ctrl_view[`CMPL_BIT_POL] = pol_reg;
      ctrl_view[`CMPL_BIT_OUT] = out_reg; // see RQ4 see RQ6
      ctrl_view[`CMPL_BIT_HYS] = hys_reg;
   end

   always_comb begin
      int_view = 8'h00;
      int_view[`CMPL_BIT_FLAG] = flag_reg;
      int_view[`CMPL_BIT_IEN] = ien_reg;
   end

   always_comb begin
      rd_data = 32'h0;
      case (WB_ADR_I)
         `CMPL_OFS_CTRL: begin
            rd_data[7:0] = ctrl_view;
         end
         `CMPL_OFS_INT: begin
            rd_data[7:0] = int_view;
         end
         `CMPL_OFS_PIN: begin
            rd_data[2:0] = sel_reg;
         end
         `CMPL_OFS_PORT: begin
            rd_data[2:0] = PORT_READ;
         end
         default: begin
            rd_data = 32'h0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         WB_DAT_O <= 32'h0;
      end else if (rd_hit) begin
         WB_DAT_O <= rd_data;
      end
   end
endmodule // cmpl_ctrl
`default_nettype wire

//--- cmpl_analog_model.sv
// cmpl_analog_model.sv: behavioural analog comparator core on the far side of the block
// assumes the bench sets which input is higher and how many cycles the core lags
`timescale 1ns/10ps
`default_nettype none
module cmpl_analog_model (
   input wire logic clk,
   input wire logic power_on,
   input wire logic pos_above,
   input wire logic [2:0] lag,
   output logic raw
);
   logic [7:0] pipe_reg = 8'h00;
   logic junk_reg = 1'b0;
   always_ff @(posedge clk) begin
      pipe_reg <= {pipe_reg[6:0], pos_above};
   end
   always_ff @(posedge clk) begin
      junk_reg <= ~junk_reg;
   end
   // an unpowered core gives no valid answer, so it chatters
   assign raw = power_on ? pipe_reg[lag] : junk_reg;
endmodule // cmpl_analog_model
`default_nettype wire

//--- cmpl_ctrl_monitor.sv
// cmpl_ctrl_monitor.sv: port assertions for the comparator control block
// assumes one clock CLK and synchronous active-high RST
`timescale 1ns/10ps
`default_nettype none
module cmpl_ctrl_monitor (
   input wire logic CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic WB_ACK_O,
   input wire logic LOW_POWER_MODE,
   input wire logic COMP_POWER_ON,
   input wire logic COMP_HYST_ON,
   input wire logic COMP_IRQ,
   input wire logic COMP_WAKE,
   input wire logic [2:0] PULLUP_CUT,
   input wire logic COMP_PIN_OUT,
   input wire logic COMP_PIN_OE_N
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   AST_OFF_LOW: assert property (!COMP_POWER_ON [*8] |-> !COMP_PIN_OUT)
      else $error("pin output high while comparator off");
   AST_NO_CUT_OUT: assert property (PULLUP_CUT[2] == 1'b0)
      else $error("pull-up cut on output pin");
   AST_WAKE_LOWPWR: assert property (COMP_WAKE |-> $past(LOW_POWER_MODE) && COMP_POWER_ON)
      else $error("wake outside low power");
   AST_WAKE_PULSE: assert property (COMP_WAKE |=> !COMP_WAKE)
      else $error("wake longer than one cycle");
   AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   AST_RESET_VALUES: assert property ($fell(RST) |-> COMP_HYST_ON && COMP_PIN_OE_N && !COMP_POWER_ON)
      else $error("bad reset value");
   AST_RESET_QUIET: assert property ($fell(RST) |-> !COMP_IRQ && !COMP_WAKE && !COMP_PIN_OUT)
      else $error("output active after reset");
   AST_EN_BY_WRITE: assert property ($changed(COMP_POWER_ON) |->
      $past(WB_CYC_I && WB_WE_I) || $past(WB_CYC_I && WB_WE_I, 2))
      else $error("power changed without write");
   COV_WAKE: cover property (COMP_WAKE);
   COV_IRQ: cover property ($rose(COMP_IRQ));
   COV_WRITE: cover property (WB_ACK_O && WB_WE_I);
endmodule // cmpl_ctrl_monitor
bind cmpl_ctrl cmpl_ctrl_monitor u_mon (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ACK_O,
   .LOW_POWER_MODE, .COMP_POWER_ON, .COMP_HYST_ON, .COMP_IRQ, .COMP_WAKE, .PULLUP_CUT,
   .COMP_PIN_OUT, .COMP_PIN_OE_N);
`default_nettype wire

//--- cmpl_ctrl_tb.sv
// cmpl_ctrl_tb.sv: self-checking bench for the comparator control block
// assumes cmpl_ctrl, cmpl_analog_model and the monitor are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module cmpl_ctrl_tb;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lpm = 1'b0, pos = 1'b0;
   logic raw, ack, pwr, hys, irq, wake, pin, oe_n;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, lfsr_reg = 32'h00015493;
   logic [2:0] pctl = 3'h0, pdat = 3'h0, lag = 3'h1, cut, prd;
   logic [31:0] expq[$];
   int mismatches = 0, check_count = 0;
   initial forever #20 clk = ~clk;
   cmpl_ctrl u_dut (.CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_WE_I(we), .WB_SEL_I(4'h1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
      .COMP_RAW(raw), .COMP_POWER_ON(pwr), .COMP_HYST_ON(hys), .LOW_POWER_MODE(lpm),
      .COMP_IRQ(irq), .COMP_WAKE(wake), .PORT_CTRL(pctl), .PORT_DATA(pdat), .PULLUP_CUT(cut),
      .PORT_READ(prd), .COMP_PIN_OUT(pin), .COMP_PIN_OE_N(oe_n));
   cmpl_analog_model u_core (.clk(clk), .power_on(pwr), .pos_above(pos), .lag(lag), .raw(raw));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one classic cycle; a read notes its expected byte for the watcher
   task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
      int n;
      if (!w) expq.push_back({24'h0, e});
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; adr <= a; we <= w; wdat <= {24'h0, d};
      n = 0;
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin mismatches++; give_verdict; end
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) chk(rdat, expq.pop_front());
   end
   initial begin
      logic [7:0] d;
      int n;
      logic seen;
      idle(6);
      rst <= 1'b0;
      wb(4'h0, 0, 0, 8'h01);
      wb(4'h4, 0, 0, 8'h00);
      wb(4'h2, 0, 0, 8'h00);
      chk(hys, 1);
      chk(oe_n, 1);
      for (int i = 0; i < 6; i++) begin
         lfsr_reg = lfsr(lfsr_reg);
         d = lfsr_reg[7:0];
         wb(4'h0, 1, d, 0);
         idle(12);
         wb(4'h0, 0, 0, (d & 8'h61) | {3'h0, d[6] & d[5], 4'h0});
         chk(pwr, d[6]);
         chk(hys, d[0]);
      end
      for (int i = 0; i < 4; i++) begin
         pos <= i[0];
         wb(4'h0, 1, {2'b01, i[1], 5'h0}, 0);
         idle(12);
         wb(4'h0, 0, 0, {2'b01, i[1], i[0] ^ i[1], 4'h0});
      end
      lag <= 3'h6;
      wb(4'h4, 1, 8'h02, 0);
      pos <= 1'b0;
      idle(16);
      chk(irq, 1);
      wb(4'h4, 0, 0, 8'h03);
      wb(4'h4, 1, 8'h02, 0);
      idle(2);
      chk(irq, 0);
      lpm <= 1'b1;
      pos <= 1'b1;
      n = 0;
      while (wake !== 1'b1 && n < 20) begin @(posedge clk); n++; end
      chk(n < 20, 1);
      if (n >= 20) give_verdict;
      wb(4'h4, 1, 8'h02, 0);
      wb(4'h4, 1, 8'h03, 0);
      pos <= 1'b0;
      seen = 1'b0;
      repeat (16) begin @(posedge clk); if (wake === 1'b1) seen = 1'b1; end
      chk(seen, 0);
      wb(4'h0, 0, 0, 8'h70);
      lpm <= 1'b0;
      lfsr_reg = lfsr(lfsr_reg);
      wb(4'h8, 1, 8'h07, 0);
      pctl <= lfsr_reg[10:8];
      pdat <= lfsr_reg[13:11];
      idle(10);
      chk(prd, 3'(~pctl & pdat));
      chk(cut, 3);
      chk(oe_n, 0);
      chk(pin, 1);
      wb(4'h0, 1, 8'h20, 0);
      idle(12);
      wb(4'h0, 0, 0, 8'h20);
      chk(pin, 0);
      idle(3);
      give_verdict;
   end
endmodule // cmpl_ctrl_tb
`default_nettype wire
